/* logic/timer_capture_consts.svh */
// named offsets, field positions, reset values and counts of the capture timer
`ifndef TIMER_CAPTURE_CONSTS_SVH
`define TIMER_CAPTURE_CONSTS_SVH

`define TC_ADDR_W          8
`define TC_DATA_W          16
`define TC_MAX_CHAN        8

`define TC_ADDR_START      8'h00
`define TC_ADDR_STOP       8'h04
`define TC_ADDR_ENABLED    8'h08
`define TC_ADDR_IRQ_STATUS 8'h0c
`define TC_ADDR_IRQ_MASK   8'h10
`define TC_ADDR_PRESCALE   8'h14

`define TC_CHAN_SPACE_BIT  7
`define TC_CHAN_IDX_LSB    4
`define TC_CHAN_IDX_W      3
`define TC_WORD_LSB        2
`define TC_OFS_MODE        2'h0
`define TC_OFS_DATA        2'h1
`define TC_OFS_STATUS      2'h2
`define TC_OFS_COUNT       2'h3

`define TC_MODE_W          9
`define TC_MODE_OP_BIT     0
`define TC_MODE_CKS_LSB    1
`define TC_MODE_STS_LSB    3
`define TC_MODE_FILT_BIT   6
`define TC_MODE_EDGE_LSB   7
`define TC_MODE_RESET      9'h000

`define TC_STS_INPUT_EDGE  3'h1
`define TC_EDGE_FALLING    2'h0
`define TC_EDGE_RISING     2'h1

`define TC_COUNT_INIT      16'h0000
`define TC_COUNT_FULL      16'hffff
`define TC_COUNT_ONE       16'h0001
`define TC_REG_RESET       16'h0000

`define TC_PRE_FIELD_W     4
`define TC_PRE_SHIFT_FULL  5'h10
`define TC_PRE_MASK_FULL   16'hffff
`define TC_DIV_ONE         16'h0001

`endif

/* logic/timer_capture_pkg.sv */
// types shared by the capture timer
package timer_capture_pkg;
    typedef enum logic [1:0] {st_off, st_wait_start, st_counting} chan_state_t;
    typedef enum logic {op_one_count, op_interval} op_mode_t;
endpackage

/* logic/timer_channel_capture.sv */
// eight-channel 16-bit capture timer: high-width and pulse-interval measurement
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "timer_capture_consts.svh"


module timer_channel_capture #(
    parameter int NUM_CHAN = 8
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // register port
    input  wire logic [`TC_ADDR_W-1:0]  reg_addr,
    input  wire logic [`TC_DATA_W-1:0]  reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [`TC_DATA_W-1:0]  reg_rdata,
    // timer input pins
    input  wire logic [NUM_CHAN-1:0]    chan_timer_input,
    // events
    output logic      [NUM_CHAN-1:0]    chan_interrupt_request,
    output logic                        irq
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    generate
        if (NUM_CHAN < 1 || NUM_CHAN > `TC_MAX_CHAN) begin : g_bad_chan
            $error("NUM_CHAN must be between 1 and 8");
        end
    endgenerate

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // prescaled tick: once every 2^expo cycles of the divider
    function automatic logic prescale_tick(input logic [15:0] div,
                                           input logic [3:0]  expo);
        logic [15:0] mask;
        mask = `TC_PRE_MASK_FULL >> (`TC_PRE_SHIFT_FULL - {1'b0, expo});
        return (div & mask) == mask;
    endfunction

    // the reduced set lets only clocks a and b through
    function automatic logic [1:0] eff_select(input int        n,
                                              input logic [1:0] cks);
        if (n == 1 || n == 3) begin
            return cks;
        end
        return {1'b0, cks[0]};
    endfunction

    function automatic logic word_hit(input logic [`TC_ADDR_W-1:0] a,
                                      input logic [`TC_ADDR_W-1:0] ref_a);
        return a == ref_a;
    endfunction

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [`TC_MODE_W-1:0]      mode_reg [NUM_CHAN];
    logic [`TC_DATA_W-1:0]      cnt_reg  [NUM_CHAN];
    logic [`TC_DATA_W-1:0]      cnt_next [NUM_CHAN];
    logic [`TC_DATA_W-1:0]      data_reg [NUM_CHAN];
    logic [`TC_DATA_W-1:0]      data_next[NUM_CHAN];
    timer_capture_pkg::chan_state_t state_reg [NUM_CHAN];
    timer_capture_pkg::chan_state_t state_next[NUM_CHAN];
    logic [NUM_CHAN-1:0]        wrap_reg;
    logic [NUM_CHAN-1:0]        wrap_next;
    logic [NUM_CHAN-1:0]        seen_reg;
    logic [NUM_CHAN-1:0]        seen_next;
    logic [NUM_CHAN-1:0]        cap_vec;
    logic [NUM_CHAN-1:0]        tick_vec;
    logic [NUM_CHAN-1:0]        enabled_vec;
    logic [NUM_CHAN-1:0]        irq_stat_reg;
    logic [NUM_CHAN-1:0]        irq_stat_next;
    logic [NUM_CHAN-1:0]        irq_mask_reg;
    logic [`TC_DATA_W-1:0]      prescale_reg;
    logic [`TC_DATA_W-1:0]      div_reg;
    logic [`TC_DATA_W-1:0]      rdata_next;

    // pin pipeline
    logic [NUM_CHAN-1:0]        sync1_reg;
    logic [NUM_CHAN-1:0]        sync2_reg;
    logic [NUM_CHAN-1:0]        samp_reg;
    logic [NUM_CHAN-1:0]        filt1_reg;
    logic [NUM_CHAN-1:0]        filt2_reg;
    logic [NUM_CHAN-1:0]        lvl_reg;
    logic [NUM_CHAN-1:0]        prv_reg;

    // register decode
    logic                       chan_hit;
    logic [`TC_CHAN_IDX_W-1:0]  chan_idx;
    logic [1:0]                 chan_ofs;

    assign chan_idx = reg_addr[`TC_CHAN_IDX_LSB +: `TC_CHAN_IDX_W];
    assign chan_ofs = reg_addr[`TC_WORD_LSB +: 2];
    assign chan_hit = reg_addr[`TC_CHAN_SPACE_BIT]
                      && (reg_addr[1:0] == 2'h0)
                      && (int'(chan_idx) < NUM_CHAN);

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_reg <= `TC_REG_RESET;
        end else begin
            div_reg <= div_reg + `TC_DIV_ONE;
        end
    end

    // operating clock of each channel as a one-cycle enable
    always_comb begin
        logic [1:0] sel;
        sel = 2'h0;
        for (int n = 0; n < NUM_CHAN; n++) begin
            sel = eff_select(n, mode_reg[n][`TC_MODE_CKS_LSB +: 2]);
            tick_vec[n] = prescale_tick(div_reg,
                prescale_reg[int'(sel) * `TC_PRE_FIELD_W +: `TC_PRE_FIELD_W]);
        end
    end

    // ------------------------------------------------------------
    // input pins
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= chan_timer_input;
            sync2_reg <= sync1_reg;
        end
    end

    // sampled on the operating clock so edges carry one clock of error
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            samp_reg  <= '0;
            filt1_reg <= '0;
            filt2_reg <= '0;
            lvl_reg   <= '0;
            prv_reg   <= '0;
        end else begin
            for (int n = 0; n < NUM_CHAN; n++) begin
                if (tick_vec[n]) begin
                    samp_reg[n]  <= sync2_reg[n];
                    filt1_reg[n] <= samp_reg[n];
                    filt2_reg[n] <= filt1_reg[n];
                    prv_reg[n]   <= lvl_reg[n];
                    if (!mode_reg[n][`TC_MODE_FILT_BIT]) begin
                        lvl_reg[n] <= samp_reg[n];
                    end else if (samp_reg[n] == filt1_reg[n]
                                 && filt1_reg[n] == filt2_reg[n]) begin
                        // three equal samples: two clocks later than unfiltered
                        lvl_reg[n] <= samp_reg[n];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // channel behaviour
    // ------------------------------------------------------------
    always_comb begin
        logic     tk;
        logic     rise;
        logic     fall;
        logic     edge_v;
        logic     pin_en;
        logic     sw_start;
        logic     sw_stop;
        logic     capture;
        timer_capture_pkg::op_mode_t op;
        tk       = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        edge_v   = 1'b0;
        pin_en   = 1'b0;
        sw_start = 1'b0;
        sw_stop  = 1'b0;
        capture  = 1'b0;
        op       = timer_capture_pkg::op_one_count;
        for (int n = 0; n < NUM_CHAN; n++) begin
            tk     = tick_vec[n];
            rise   = lvl_reg[n] & ~prv_reg[n];
            fall   = ~lvl_reg[n] & prv_reg[n];
            op     = timer_capture_pkg::op_mode_t'(mode_reg[n][`TC_MODE_OP_BIT]);
            pin_en = mode_reg[n][`TC_MODE_STS_LSB +: 3] == `TC_STS_INPUT_EDGE;
            unique case (mode_reg[n][`TC_MODE_EDGE_LSB +: 2])
                `TC_EDGE_FALLING: edge_v = fall;
                `TC_EDGE_RISING:  edge_v = rise;
                default:          edge_v = rise | fall;
            endcase
            sw_start = reg_wr && word_hit(reg_addr, `TC_ADDR_START) && reg_wdata[n];
            sw_stop  = reg_wr && word_hit(reg_addr, `TC_ADDR_STOP) && reg_wdata[n];
            capture  = 1'b0;
            state_next[n] = state_reg[n];
            cnt_next[n]   = cnt_reg[n];
            seen_next[n]  = seen_reg[n];
            data_next[n]  = data_reg[n];
            wrap_next[n]  = wrap_reg[n];
            if (sw_stop) begin
                state_next[n] = timer_capture_pkg::st_off;
            end else if (state_reg[n] == timer_capture_pkg::st_off) begin
                if (sw_start) begin
                    if (op == timer_capture_pkg::op_interval) begin
                        state_next[n] = timer_capture_pkg::st_counting;
                        cnt_next[n]   = `TC_COUNT_INIT;
                        seen_next[n]  = 1'b0;
                    end else begin
                        // counter keeps its value until the rising edge
                        state_next[n] = timer_capture_pkg::st_wait_start;
                    end
                end
            end else if (op == timer_capture_pkg::op_interval) begin
                if (sw_start || (tk && pin_en && edge_v)) begin
                    capture       = 1'b1;
                    cnt_next[n]   = `TC_COUNT_INIT;
                    state_next[n] = timer_capture_pkg::st_counting;
                end else if (tk) begin
                    cnt_next[n] = cnt_reg[n] + `TC_COUNT_ONE;
                    if (cnt_reg[n] == `TC_COUNT_FULL) begin
                        seen_next[n] = 1'b1;
                    end
                end
            end else if (state_reg[n] == timer_capture_pkg::st_wait_start) begin
                if (tk && pin_en && rise) begin
                    state_next[n] = timer_capture_pkg::st_counting;
                    cnt_next[n]   = `TC_COUNT_INIT;
                    seen_next[n]  = 1'b0;
                end
            end else begin
                if (tk && pin_en && fall) begin
                    capture       = 1'b1;
                    state_next[n] = timer_capture_pkg::st_wait_start;
                end else if (tk) begin
                    cnt_next[n] = cnt_reg[n] + `TC_COUNT_ONE;
                    if (cnt_reg[n] == `TC_COUNT_FULL) begin
                        seen_next[n] = 1'b1;
                    end
                end
            end
            if (capture) begin
                // captured value plus wrap flag give periods or high widths of up to twice the counter range
                data_next[n] = cnt_reg[n];
                wrap_next[n] = seen_reg[n];
                seen_next[n] = 1'b0;
            end
            cap_vec[n]     = capture;
            enabled_vec[n] = state_reg[n] != timer_capture_pkg::st_off;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int n = 0; n < NUM_CHAN; n++) begin
                state_reg[n] <= timer_capture_pkg::st_off;
                cnt_reg[n]   <= `TC_COUNT_INIT;
                data_reg[n]  <= `TC_REG_RESET;
            end
            seen_reg <= '0;
            wrap_reg <= '0;
        end else begin
            for (int n = 0; n < NUM_CHAN; n++) begin
                state_reg[n] <= state_next[n];
                cnt_reg[n]   <= cnt_next[n];
                data_reg[n]  <= data_next[n];
            end
            seen_reg <= seen_next;
            wrap_reg <= wrap_next;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int n = 0; n < NUM_CHAN; n++) begin
                mode_reg[n] <= `TC_MODE_RESET;
            end
            prescale_reg <= `TC_REG_RESET;
            irq_mask_reg <= '0;
        end else if (reg_wr) begin
            if (chan_hit && chan_ofs == `TC_OFS_MODE) begin
                mode_reg[chan_idx] <= reg_wdata[`TC_MODE_W-1:0];
            end
            if (word_hit(reg_addr, `TC_ADDR_PRESCALE)) begin
                prescale_reg <= reg_wdata;
            end
            if (word_hit(reg_addr, `TC_ADDR_IRQ_MASK)) begin
                irq_mask_reg <= reg_wdata[NUM_CHAN-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    // a capture in the clearing cycle survives the write of one
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (reg_wr && word_hit(reg_addr, `TC_ADDR_IRQ_STATUS)) begin
            irq_stat_next = irq_stat_reg & ~reg_wdata[NUM_CHAN-1:0];
        end
        irq_stat_next = irq_stat_next | cap_vec;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_stat_reg           <= '0;
            irq                    <= 1'b0;
            chan_interrupt_request <= '0;
        end else begin
            irq_stat_reg           <= irq_stat_next;
            irq                    <= |(irq_stat_next & irq_mask_reg);
            chan_interrupt_request <= cap_vec;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = `TC_REG_RESET;
        if (chan_hit) begin
            unique case (chan_ofs)
                `TC_OFS_MODE:   rdata_next = `TC_DATA_W'(mode_reg[chan_idx]);
                `TC_OFS_DATA:   rdata_next = data_reg[chan_idx];
                `TC_OFS_STATUS: rdata_next = `TC_DATA_W'(wrap_reg[chan_idx]);
                `TC_OFS_COUNT:  rdata_next = cnt_reg[chan_idx];
            endcase
        end else if (word_hit(reg_addr, `TC_ADDR_ENABLED)) begin
            rdata_next = `TC_DATA_W'(enabled_vec);
        end else if (word_hit(reg_addr, `TC_ADDR_IRQ_STATUS)) begin
            rdata_next = `TC_DATA_W'(irq_stat_reg);
        end else if (word_hit(reg_addr, `TC_ADDR_IRQ_MASK)) begin
            rdata_next = `TC_DATA_W'(irq_mask_reg);
        end else if (word_hit(reg_addr, `TC_ADDR_PRESCALE)) begin
            rdata_next = prescale_reg;
        end
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= `TC_REG_RESET;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= `TC_REG_RESET;
        end
    end

endmodule // timer_channel_capture

/* sim/timer_capture_chk.sv */
// bound checker of register-port, capture-pulse and interrupt timing of the capture timer
`timescale 1ns/1ps
`include "timer_capture_consts.svh"

module timer_capture_chk #(
    parameter int NUM_CHAN = 8
) (
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic [`TC_ADDR_W-1:0] reg_addr,
    input wire logic [`TC_DATA_W-1:0] reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [`TC_DATA_W-1:0] reg_rdata,
    input wire logic [NUM_CHAN-1:0]   chan_timer_input,
    input wire logic [NUM_CHAN-1:0]   chan_interrupt_request,
    input wire logic                  irq
);
    // ------------------------------------------------------------
    // shadow of the software-written state
    // ------------------------------------------------------------
    logic [NUM_CHAN-1:0] en_reg;
    logic [NUM_CHAN-1:0] mask_reg;
    logic                op0_reg;
    wire  [NUM_CHAN-1:0] wd = reg_wdata[NUM_CHAN-1:0];
    wire clr = reg_wr && (reg_addr == `TC_ADDR_IRQ_STATUS || reg_addr == `TC_ADDR_IRQ_MASK);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_reg <= '0;
            mask_reg <= '0;
            op0_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `TC_ADDR_START) en_reg <= en_reg | wd;
            else if (reg_wr && reg_addr == `TC_ADDR_STOP) en_reg <= en_reg & ~wd;
            if (reg_wr && reg_addr == `TC_ADDR_IRQ_MASK) mask_reg <= wd;
            if (reg_wr && reg_addr == 8'h80) op0_reg <= reg_wdata[0];
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_start;
        reg_wr && reg_addr == `TC_ADDR_START;
    endsequence
    sequence s_stop;
        reg_wr && reg_addr == `TC_ADDR_STOP;
    endsequence
    sequence s_en_rd;
        reg_rd && reg_addr == `TC_ADDR_ENABLED;
    endsequence

    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside a read answer");
    AST_START_ENABLES: assert property (
        s_start ##2 s_en_rd |=> (reg_rdata[NUM_CHAN-1:0] & $past(wd, 3)) == $past(wd, 3))
        else $error("started channel not shown enabled");
    AST_STOP_DISABLES: assert property (
        s_stop ##2 s_en_rd |=> (reg_rdata[NUM_CHAN-1:0] & $past(wd, 3)) == '0)
        else $error("stopped channel still shown enabled");
    AST_SW_CAPTURE: assert property (
        s_start and (reg_wdata[0] && en_reg[0] && op0_reg) |-> ##[1:3] chan_interrupt_request[0])
        else $error("software capture gave no pulse");
    AST_IRQ_FOLLOWS_PULSE: assert property (
        (chan_interrupt_request & mask_reg) != '0 |=> irq)
        else $error("unmasked capture did not raise irq");
    AST_IRQ_STICKY: assert property (irq && !clr && !$past(clr) |=> irq)
        else $error("irq dropped without a clear");
    AST_MASKED_QUIET: assert property (mask_reg == '0 |=> !irq)
        else $error("irq high with all sources masked");
    // pulse trails the capture decision by one cycle; the second past value is slack
    AST_NO_PULSE_OFF: assert property (
        (chan_interrupt_request & ~($past(en_reg) | $past(en_reg, 2))) == '0)
        else $error("capture pulse on a disabled channel");
endmodule // timer_capture_chk

bind timer_channel_capture timer_capture_chk #(.NUM_CHAN(NUM_CHAN)) i_chk (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_timer_input(chan_timer_input),
    .chan_interrupt_request(chan_interrupt_request), .irq(irq));

/* sim/pin_source.sv */
// external pulse source driving the timer input pins
`timescale 1ns/1ps

module pin_source #(
    parameter int NUM_CHAN = 8
) (
    // clock
    input  wire logic                ref_clk,
    // timer input pins
    output logic      [NUM_CHAN-1:0] pins
);
    int cyc = 0;
    int last [NUM_CHAN];

    initial pins = '0;
    always @(posedge ref_clk) cyc <= cyc + 1;

    // next rise lands p edges after the previous one; p of 0 means ten edges from now
    // hazard: the caller must return before the target edge has passed
    task automatic rise_at(input int ch, input int p);
        int target;
        target = (p == 0) ? cyc + 10 : last[ch] + p;
        @(posedge ref_clk);
        pins[ch] <= 1'b0;
        while (cyc != target) @(posedge ref_clk);
        pins[ch] <= 1'b1;
        last[ch] = cyc;
    endtask

    task automatic high_width(input int ch, input int w);
        @(posedge ref_clk);
        pins[ch] <= 1'b1;
        repeat (w) @(posedge ref_clk);
        pins[ch] <= 1'b0;
    endtask
endmodule // pin_source

/* sim/timer_channel_capture_tb.sv */
// self-checking bench of the capture timer: registers, interval, width and interrupts
`timescale 1ns/1ps
`include "timer_capture_consts.svh"

module timer_channel_capture_tb;
    // ------------------------------------------------------------
    // clock, reset and instances
    // ------------------------------------------------------------
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [7:0]  pins;
    logic [7:0]  chan_interrupt_request;
    logic        irq;
    logic [15:0] rv;
    int          failures = 0;
    int          n_compared = 0;
    int          seed = 3286;
    int          p;
    int          lat0;
    int          lat;

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    timer_channel_capture #(.NUM_CHAN(8)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_timer_input(pins),
        .chan_interrupt_request(chan_interrupt_request), .irq(irq));
    pin_source #(.NUM_CHAN(8)) i_src (.ref_clk(ref_clk), .pins(pins));

    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    function automatic logic [7:0] base(input int ch, input logic [1:0] ofs);
        return 8'h80 + 8'(ch * 16) + {4'h0, ofs, 2'b00};
    endfunction
    function automatic logic [15:0] mode_word(input bit op, input int cks, input bit filt);
        return 16'(op) | 16'(cks << 1) | 16'h0088 | (filt ? 16'h0040 : 16'h0000);
    endfunction
    function automatic logic [15:0] exp_data(input int span, input int tick);
        return 16'(span / tick - 1);
    endfunction

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        rd(a, rv);
        chk_word(rv, e);
    endtask
    // looks once a cycle just after the edge, so a one-cycle pulse cannot slip by
    task automatic wait_pulse(input int ch, input logic e, output int n);
        n = 0;
        #1;
        while (chan_interrupt_request[ch] !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        chk_flag(chan_interrupt_request[ch], e);
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        // the wrap test dominates at about 66k cycles
        repeat (90000) @(posedge ref_clk);
        failures++;
        summarize();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rchk(`TC_ADDR_IRQ_MASK, 16'h0000);
        rchk(`TC_ADDR_PRESCALE, 16'h0000);
        rchk(base(5, `TC_OFS_DATA), 16'h0000);
        wr(`TC_ADDR_ENABLED, 16'h00ff);
        rchk(`TC_ADDR_ENABLED, 16'h0000);
        rchk(8'h18, 16'h0000);
        $display("test reset done");
        wr(base(0, `TC_OFS_MODE), mode_word(1, 0, 0));
        wr(`TC_ADDR_IRQ_MASK, 16'h0001);
        wr(`TC_ADDR_START, 16'h0001);
        rchk(`TC_ADDR_ENABLED, 16'h0001);
        i_src.rise_at(0, 0);
        wait_pulse(0, 1'b1, lat0);
        repeat (3) begin
            p = 40 + ($random(seed) & 63);
            i_src.rise_at(0, p);
            wait_pulse(0, 1'b1, lat0);
            rchk(base(0, `TC_OFS_DATA), exp_data(p, 1));
            rchk(base(0, `TC_OFS_STATUS), 16'h0000);
        end
        chk_flag(irq, 1'b1);
        wr(`TC_ADDR_IRQ_MASK, 16'h0000);
        tick();
        chk_flag(irq, 1'b0);
        wr(`TC_ADDR_IRQ_MASK, 16'h0001);
        tick();
        chk_flag(irq, 1'b1);
        wr(`TC_ADDR_IRQ_STATUS, 16'h0001);
        rchk(`TC_ADDR_IRQ_STATUS, 16'h0000);
        chk_flag(irq, 1'b0);
        $display("test interval done");
        i_src.rise_at(0, 65573);
        wait_pulse(0, 1'b1, lat);
        rchk(base(0, `TC_OFS_DATA), 16'h0024);
        rchk(base(0, `TC_OFS_STATUS), 16'h0001);
        i_src.rise_at(0, 50);
        wait_pulse(0, 1'b1, lat);
        rchk(base(0, `TC_OFS_STATUS), 16'h0000);
        wr(`TC_ADDR_START, 16'h0001);
        wait_pulse(0, 1'b1, lat);
        wr(`TC_ADDR_STOP, 16'h0001);
        rchk(`TC_ADDR_ENABLED, 16'h0000);
        i_src.rise_at(0, 0);
        wait_pulse(0, 1'b0, lat);
        $display("test wrap done");
        wr(base(2, `TC_OFS_MODE), mode_word(1, 0, 1));
        wr(`TC_ADDR_START, 16'h0004);
        i_src.rise_at(2, 0);
        wait_pulse(2, 1'b1, lat);
        chk_word(16'(lat), 16'(lat0 + 2));
        wr(base(3, `TC_OFS_MODE), mode_word(1, 0, 0) & 16'hfff7);
        wr(`TC_ADDR_START, 16'h0008);
        i_src.rise_at(3, 0);
        wait_pulse(3, 1'b0, lat);
        $display("test filter done");
        wr(`TC_ADDR_PRESCALE, 16'h2000);
        rchk(`TC_ADDR_PRESCALE, 16'h2000);
        wr(base(1, `TC_OFS_MODE), mode_word(1, 3, 0));
        wr(`TC_ADDR_START, 16'h0002);
        i_src.rise_at(1, 0);
        wait_pulse(1, 1'b1, lat);
        repeat (2) begin
            p = 4 * (20 + ($random(seed) & 15));
            i_src.rise_at(1, p);
            wait_pulse(1, 1'b1, lat);
            rchk(base(1, `TC_OFS_DATA), exp_data(p, 4));
        end
        $display("test prescale done");
        wr(base(4, `TC_OFS_MODE), mode_word(0, 0, 0));
        wr(`TC_ADDR_START, 16'h0010);
        repeat (5) tick();
        rchk(base(4, `TC_OFS_COUNT), 16'h0000);
        repeat (2) begin
            p = 20 + ($random(seed) & 31);
            i_src.high_width(4, p);
            wait_pulse(4, 1'b1, lat);
            rchk(base(4, `TC_OFS_DATA), exp_data(p, 1));
            repeat (5) tick();
            rchk(base(4, `TC_OFS_COUNT), exp_data(p, 1));
        end
        // both edges on channel five, falling edges only on channel six
        wr(base(5, `TC_OFS_MODE), mode_word(1, 0, 0) ^ 16'h0180);
        wr(base(6, `TC_OFS_MODE), mode_word(1, 0, 0) ^ 16'h0080);
        wr(`TC_ADDR_START, 16'h0060);
        p = 20 + ($random(seed) & 31);
        i_src.high_width(5, p);
        wait_pulse(5, 1'b1, lat);
        rchk(base(5, `TC_OFS_DATA), exp_data(p, 1));
        i_src.high_width(6, p);
        wait_pulse(6, 1'b1, lat);
        $display("test width done");
        summarize();
    end
endmodule // timer_channel_capture_tb
